// ==== rtl/dual_timer_counter_extint.sv ====
// two timer/counters with shared mode and control registers and two external interrupt flags
// assumes clk is the oscillator, pins are asynchronous, acknowledges come from the same clock
`default_nettype none


module dual_timer_counter_extint (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // pins
   input wire tmr_pkg::pins_s pins,
   // interrupt requests and service acknowledges
   input wire tmr_pkg::irq_s irq_ack,
   output tmr_pkg::irq_s irq_req
);

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   // returns {overflow, high, low} after one count step
   function automatic logic [16:0] count_step(input logic [1:0] mode, input logic [7:0] lo,
                                               input logic [7:0] hi);
      logic [13:0] c13;
      logic [16:0] c16;
      logic [8:0] c8;
      c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      c16 = {1'b0, hi, lo} + 17'h00001;
      c8 = {1'b0, lo} + 9'h001;
      case (mode)
         tmr_pkg::MODE_13: count_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
         tmr_pkg::MODE_16: count_step = c16;
         tmr_pkg::MODE_RELOAD: count_step = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
         default: count_step = {c8[8], hi, c8[7:0]};
      endcase
   endfunction

   function automatic logic wr_to(input logic wr, input logic [7:0] addr, input logic [7:0] a);
      wr_to = wr && (addr == a);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // reset release

   logic rst_q_r;
   logic rst_n_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_q_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_q_r <= 1'b1;
         rst_n_r <= rst_q_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // machine cycle

   logic [3:0] div_r;
   logic tick;

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         div_r <= 4'h0;
      end else if (div_r == tmr_pkg::MACHINE_LAST) begin
         div_r <= 4'h0;
      end else begin
         div_r <= div_r + 4'h1;
      end
   end

   assign tick = (div_r == tmr_pkg::MACHINE_LAST);

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and machine cycle samplers

   tmr_pkg::pins_s sync1_r;
   tmr_pkg::pins_s sync2_r;
   tmr_pkg::pins_s sync3_r;
   tmr_pkg::pins_s stable_r;
   tmr_pkg::pins_s samp_r;
   tmr_pkg::pins_s prev_r;
   tmr_pkg::pins_s fall;

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sync1_r <= '1;
         sync2_r <= '1;
         sync3_r <= '1;
         stable_r <= '1;
      end else begin
         sync1_r <= pins;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         for (int i = 0; i < 4; i++) begin
            if (sync2_r[i] == sync3_r[i]) begin
               stable_r[i] <= sync3_r[i];
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         samp_r <= '1;
         prev_r <= '1;
      end else if (tick) begin
         samp_r <= stable_r;
         prev_r <= samp_r;
      end
   end

   // high then low, evaluated once per tick
   assign fall = tick ? (prev_r & ~samp_r) : '0;

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   tmr_pkg::timer_mode_select_s timer_mode_select_r;
   tmr_pkg::timer_control_and_ext_int_s timer_control_and_ext_int_r;
   tmr_pkg::timer_control_and_ext_int_s timer_control_and_ext_int_nxt;
   logic [7:0] zlo_r;
   logic [7:0] zhi_r;
   logic [7:0] olo_r;
   logic [7:0] ohi_r;

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         timer_mode_select_r <= tmr_pkg::TIMER_MODE_SELECT_RST;
      end else if (wr_to(reg_wr, reg_addr, tmr_pkg::TIMER_MODE_SELECT_ADDR)) begin
         timer_mode_select_r <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // count enables

   logic split0;
   logic en0;
   logic en1;
   logic cnt0;
   logic cnt1;
   logic zhi_cnt;
   logic [16:0] res0;
   logic [16:0] res1;
   logic ovf0;
   logic ovf1;

   assign split0 = (timer_mode_select_r.zero_mode == tmr_pkg::MODE_SPLIT);

   // run bit, optionally gated by the interrupt pin level
   assign en0 = timer_control_and_ext_int_r.zero_run_bit && (!timer_mode_select_r.zero_gating_enable || samp_r.ext_irq_a_pin);
   // split mode on timer one blocks it
   assign en1 = timer_control_and_ext_int_r.one_run_bit && (!timer_mode_select_r.one_gating_enable || samp_r.ext_irq_b_pin)
                && (timer_mode_select_r.one_mode != tmr_pkg::MODE_SPLIT);

   // pick count pin events or machine cycles
   assign cnt0 = en0 && (timer_mode_select_r.zero_source_select ? fall.zero_count_pin : tick);
   assign cnt1 = en1 && (timer_mode_select_r.one_source_select ? fall.one_count_pin : tick);

   // split high byte: machine cycles, timer one run bit
   assign zhi_cnt = split0 && tick && timer_control_and_ext_int_r.one_run_bit;

   assign res0 = count_step(timer_mode_select_r.zero_mode, zlo_r, zhi_r);
   assign res1 = count_step(timer_mode_select_r.one_mode, olo_r, ohi_r);

   assign ovf0 = cnt0 && res0[16];
   // split high byte flags timer one
   assign ovf1 = (cnt1 && res1[16]) || (zhi_cnt && (zhi_r == 8'hFF));

   ////////////////////////////////////////////////////////////////////////////////
   // counters

   // timer zero low byte, loaded from the high byte on overflow in reload mode
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         zlo_r <= tmr_pkg::COUNT_RST;
      end else if (wr_to(reg_wr, reg_addr, tmr_pkg::ZERO_LOW_ADDR)) begin
         zlo_r <= reg_wdata;
      end else if (cnt0) begin
         zlo_r <= res0[7:0];
      end
   end

   // timer zero high byte, split or chained
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         zhi_r <= tmr_pkg::COUNT_RST;
      end else if (wr_to(reg_wr, reg_addr, tmr_pkg::ZERO_HIGH_ADDR)) begin
         zhi_r <= reg_wdata;
      end else if (zhi_cnt) begin
         zhi_r <= zhi_r + 8'h01;
      end else if (cnt0 && !split0) begin
         zhi_r <= res0[15:8];
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         olo_r <= tmr_pkg::COUNT_RST;
      end else if (wr_to(reg_wr, reg_addr, tmr_pkg::ONE_LOW_ADDR)) begin
         olo_r <= reg_wdata;
      end else if (cnt1) begin
         olo_r <= res1[7:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ohi_r <= tmr_pkg::COUNT_RST;
      end else if (wr_to(reg_wr, reg_addr, tmr_pkg::ONE_HIGH_ADDR)) begin
         ohi_r <= reg_wdata;
      end else if (cnt1) begin
         ohi_r <= res1[15:8];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control register and flags

   always_comb begin
      timer_control_and_ext_int_nxt = timer_control_and_ext_int_r;
      if (wr_to(reg_wr, reg_addr, tmr_pkg::TIMER_CONTROL_AND_EXT_INT_ADDR)) begin
         timer_control_and_ext_int_nxt = reg_wdata;
      end
      if (irq_ack.zero_ovf) begin
         timer_control_and_ext_int_nxt.zero_overflow_flag = 1'b0;
      end
      if (irq_ack.one_ovf) begin
         timer_control_and_ext_int_nxt.one_overflow_flag = 1'b0;
      end
      if (irq_ack.ext_a && timer_control_and_ext_int_r.ext_irq_a_type) begin
         timer_control_and_ext_int_nxt.ext_irq_a_flag = 1'b0;
      end
      if (irq_ack.ext_b && timer_control_and_ext_int_r.ext_irq_b_type) begin
         timer_control_and_ext_int_nxt.ext_irq_b_flag = 1'b0;
      end
      // hardware set wins over any clear
      if (ovf0) begin
         timer_control_and_ext_int_nxt.zero_overflow_flag = 1'b1;
      end
      if (ovf1) begin
         timer_control_and_ext_int_nxt.one_overflow_flag = 1'b1;
      end
      // falling edge or sampled low level
      if (timer_control_and_ext_int_r.ext_irq_a_type ? fall.ext_irq_a_pin : (tick && !samp_r.ext_irq_a_pin)) begin
         timer_control_and_ext_int_nxt.ext_irq_a_flag = 1'b1;
      end
      if (timer_control_and_ext_int_r.ext_irq_b_type ? fall.ext_irq_b_pin : (tick && !samp_r.ext_irq_b_pin)) begin
         timer_control_and_ext_int_nxt.ext_irq_b_flag = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         timer_control_and_ext_int_r <= tmr_pkg::TIMER_CONTROL_AND_EXT_INT_RST;
      end else begin
         timer_control_and_ext_int_r <= timer_control_and_ext_int_nxt;
      end
   end

   assign irq_req = {timer_control_and_ext_int_r.zero_overflow_flag, timer_control_and_ext_int_r.one_overflow_flag,
                     timer_control_and_ext_int_r.ext_irq_a_flag, timer_control_and_ext_int_r.ext_irq_b_flag};

   ////////////////////////////////////////////////////////////////////////////////
   // read port

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            tmr_pkg::TIMER_CONTROL_AND_EXT_INT_ADDR: reg_rdata <= timer_control_and_ext_int_r;
            tmr_pkg::TIMER_MODE_SELECT_ADDR: reg_rdata <= timer_mode_select_r;
            tmr_pkg::ZERO_LOW_ADDR: reg_rdata <= zlo_r;
            tmr_pkg::ONE_LOW_ADDR: reg_rdata <= olo_r;
            tmr_pkg::ZERO_HIGH_ADDR: reg_rdata <= zhi_r;
            tmr_pkg::ONE_HIGH_ADDR: reg_rdata <= ohi_r;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n_r);

   logic [3:0] gap_r;

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         gap_r <= 4'h0;
      end else if (tick) begin
         gap_r <= 4'h0;
      end else begin
         gap_r <= gap_r + 4'h1;
      end
   end

   a_machine_tick_period: assert property (
      tick == (gap_r == tmr_pkg::MACHINE_LAST))
      else $error("machine cycle is not twelve clocks");

   a_timer_step_sixteen: assert property (
      (cnt0 && timer_mode_select_r.zero_mode == tmr_pkg::MODE_16 && !reg_wr)
      |=> {zhi_r, zlo_r} == $past({zhi_r, zlo_r}) + 16'h0001)
      else $error("16-bit timer did not advance by one");

   a_pin_edge_count: assert property (
      (cnt0 && timer_mode_select_r.zero_source_select) |-> (tick && prev_r.zero_count_pin
                                               && !samp_r.zero_count_pin))
      else $error("count without high then low sample");

   a_thirteen_wrap: assert property (
      (cnt0 && timer_mode_select_r.zero_mode == tmr_pkg::MODE_13 && zhi_r == 8'hFF && zlo_r[4:0] == 5'h1F
       && !reg_wr) |=> (zhi_r == 8'h00 && zlo_r[4:0] == 5'h00 && timer_control_and_ext_int_r.zero_overflow_flag))
      else $error("13-bit chain did not wrap");

   a_reload_low_byte: assert property (
      (cnt1 && res1[16] && timer_mode_select_r.one_mode == tmr_pkg::MODE_RELOAD && !reg_wr)
      |=> (olo_r == ohi_r && ohi_r == $past(ohi_r) && timer_control_and_ext_int_r.one_overflow_flag))
      else $error("auto-reload did not copy high byte");

   a_overflow_ack_clear: assert property (
      (irq_ack.zero_ovf && !ovf0 && !reg_wr) |=> !timer_control_and_ext_int_r.zero_overflow_flag)
      else $error("overflow flag not cleared on service");

   a_stopped_holds: assert property (
      (!timer_control_and_ext_int_r.zero_run_bit && !reg_wr) [*2] |-> $stable(zlo_r))
      else $error("timer zero counted while stopped");

   a_gate_blocks: assert property (
      (timer_mode_select_r.zero_gating_enable && !samp_r.ext_irq_a_pin) |-> !cnt0)
      else $error("gated timer counted with pin low");

   a_split_one_stops: assert property (
      (timer_mode_select_r.one_mode == tmr_pkg::MODE_SPLIT && !reg_wr) |=> $stable({ohi_r, olo_r}))
      else $error("timer one counted in split mode");

   a_split_high_flags: assert property (
      (zhi_cnt && zhi_r == 8'hFF && !reg_wr) |=> (zhi_r == 8'h00 && timer_control_and_ext_int_r.one_overflow_flag))
      else $error("split high byte did not flag timer one");

   a_level_flag_kept: assert property (
      (timer_control_and_ext_int_r.ext_irq_b_flag && !timer_control_and_ext_int_r.ext_irq_b_type && irq_ack.ext_b && !reg_wr)
      |=> timer_control_and_ext_int_r.ext_irq_b_flag)
      else $error("level flag cleared by service");

   a_edge_flag_set: assert property (
      (timer_control_and_ext_int_r.ext_irq_a_type && fall.ext_irq_a_pin) |=> timer_control_and_ext_int_r.ext_irq_a_flag)
      else $error("falling edge did not set flag");

endmodule

`default_nettype wire

// ==== rtl/tmr_pkg.sv ====
// shared constants, register layouts and carrier types of the dual timer/counter
// assumes one core clock; the machine cycle is derived inside the block
`default_nettype none

package tmr_pkg;

   // register addresses
   localparam logic [7:0] TIMER_CONTROL_AND_EXT_INT_ADDR = 8'h88;
   localparam logic [7:0] TIMER_MODE_SELECT_ADDR = 8'h89;
   localparam logic [7:0] ZERO_LOW_ADDR = 8'h8A;
   localparam logic [7:0] ONE_LOW_ADDR = 8'h8B;
   localparam logic [7:0] ZERO_HIGH_ADDR = 8'h8C;
   localparam logic [7:0] ONE_HIGH_ADDR = 8'h8D;

   // values after reset
   localparam logic [7:0] TIMER_CONTROL_AND_EXT_INT_RST = 8'h00;
   localparam logic [7:0] TIMER_MODE_SELECT_RST = 8'h00;
   localparam logic [7:0] COUNT_RST = 8'h00;

   // core clocks per machine cycle
   localparam int MACHINE_DIV = 12;
   localparam logic [3:0] MACHINE_LAST = 4'(MACHINE_DIV - 1);

   // mode field encodings
   localparam logic [1:0] MODE_13 = 2'h0;
   localparam logic [1:0] MODE_16 = 2'h1;
   localparam logic [1:0] MODE_RELOAD = 2'h2;
   localparam logic [1:0] MODE_SPLIT = 2'h3;

   typedef struct packed {
      logic one_gating_enable;
      logic one_source_select;
      logic [1:0] one_mode;
      logic zero_gating_enable;
      logic zero_source_select;
      logic [1:0] zero_mode;
   } timer_mode_select_s;

   typedef struct packed {
      logic one_overflow_flag;
      logic one_run_bit;
      logic zero_overflow_flag;
      logic zero_run_bit;
      logic ext_irq_b_flag;
      logic ext_irq_b_type;
      logic ext_irq_a_flag;
      logic ext_irq_a_type;
   } timer_control_and_ext_int_s;

   // external pins
   typedef struct packed {
      logic zero_count_pin;
      logic one_count_pin;
      logic ext_irq_a_pin;
      logic ext_irq_b_pin;
   } pins_s;

   // interrupt requests out, service acknowledges in
   typedef struct packed {
      logic zero_ovf;
      logic one_ovf;
      logic ext_a;
      logic ext_b;
   } irq_s;

endpackage

`default_nettype wire

// ==== sim/dual_timer_counter_extint_test.sv ====
// self-checking bench of the dual timer/counter
// assumes pin_source drives the pins and the bench owns register port and acknowledges
`default_nettype none

`define CHK(got, exp) \
   begin \
      compares++; \
      if ((got) !== (exp)) begin \
         $display("Error t=%0t got %h exp %h", $time, got, exp); \
         miscompares++; \
      end \
   end

module dual_timer_counter_extint_test;
   timeunit 1ns;
   timeprecision 100ps;

   localparam logic [7:0] CT = tmr_pkg::TIMER_CONTROL_AND_EXT_INT_ADDR;
   localparam logic [7:0] ZL = tmr_pkg::ZERO_LOW_ADDR;
   localparam logic [7:0] ZH = tmr_pkg::ZERO_HIGH_ADDR;
   localparam logic [7:0] OL = tmr_pkg::ONE_LOW_ADDR;
   localparam logic [7:0] OH = tmr_pkg::ONE_HIGH_ADDR;

   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   tmr_pkg::pins_s pins;
   tmr_pkg::irq_s irq_ack = '0;
   tmr_pkg::irq_s irq_req;
   tmr_pkg::irq_s req_seen;
   int miscompares = 0;
   int compares = 0;
   int cycles = 0;
   // address, write data, read back
   logic [23:0] rows [7] = '{24'h89A5A5, 24'h8A3C3C, 24'h8BC3C3, 24'h8C5A5A,
                             24'h8DA5A5, 24'h90FF00, 24'h880505};

   dual_timer_counter_extint dual_timer_counter_extint_i (
      .clk(clk),
      .resetn(resetn),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .pins(pins),
      .irq_ack(irq_ack),
      .irq_req(irq_req)
   );

   pin_source pin_source_i (
      .clk(clk),
      .pins(pins)
   );

   always #12.5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////

   task automatic print_verdict();
      if (miscompares == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         miscompares++;
         print_verdict();
      end
   end

   task automatic do_reset();
      resetn <= 1'b0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask

   task automatic setup(input logic [7:0] md, input logic [7:0] la, input logic [7:0] lv,
                        input logic [7:0] ha, input logic [7:0] hv);
      wr(tmr_pkg::TIMER_MODE_SELECT_ADDR, md);
      wr(la, lv);
      wr(ha, hv);
   endtask

   // run bits on for exactly k machine cycles; flags noted before the stop write
   task automatic run_for(input logic [7:0] on, input logic [7:0] off, input int k);
      wr(CT, on);
      repeat (tmr_pkg::MACHINE_DIV * k - 2) @(posedge clk);
      #1;
      req_seen = irq_req;
      wr(CT, off);
   endtask

   task automatic ack(input int b);
      @(posedge clk);
      irq_ack[b] <= 1'b1;
      @(posedge clk);
      irq_ack <= '0;
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////

   initial begin
      do_reset();
      rchk(CT, 8'h00);
      rchk(OH, 8'h00);
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rchk(rows[i][23:16], rows[i][7:0]);
      end
      wr(CT, 8'h00);
      setup(8'h01, ZL, 8'hFE, ZH, 8'hFF);
      run_for(8'h10, 8'h20, 3);
      `CHK(req_seen.zero_ovf, 1'b1)
      rchk(ZL, 8'h01);
      rchk(ZH, 8'h00);
      repeat (40) @(posedge clk);
      rchk(ZL, 8'h01);
      ack(3);
      `CHK(irq_req.zero_ovf, 1'b0)
      setup(8'h00, ZL, 8'hFE, ZH, 8'hFF);
      run_for(8'h10, 8'h00, 3);
      `CHK(req_seen.zero_ovf, 1'b1)
      rchk(ZL, 8'hE1);
      rchk(ZH, 8'h00);
      setup(8'h20, OL, 8'hFE, OH, 8'h80);
      run_for(8'h40, 8'h00, 3);
      `CHK(req_seen.one_ovf, 1'b1)
      rchk(OL, 8'h81);
      rchk(OH, 8'h80);
      setup(8'h33, ZL, 8'hFF, ZH, 8'hFE);
      wr(OL, 8'h55);
      run_for(8'h50, 8'h00, 3);
      `CHK(req_seen[3:2], 2'h3)
      rchk(ZL, 8'h02);
      rchk(ZH, 8'h01);
      rchk(OL, 8'h55);
      setup(8'h09, ZL, 8'h00, ZH, 8'h00);
      pin_source_i.drive(1, 1'b0);
      repeat (30) @(posedge clk);
      run_for(8'h10, 8'h00, 4);
      rchk(ZL, 8'h00);
      pin_source_i.drive(1, 1'b1);
      repeat (30) @(posedge clk);
      run_for(8'h10, 8'h00, 4);
      rchk(ZL, 8'h04);
      setup(8'h55, ZL, 8'h00, ZH, 8'h00);
      wr(OL, 8'h00);
      wr(CT, 8'h50);
      repeat (3) pin_source_i.pulse(3);
      repeat (2) pin_source_i.pulse(2);
      wr(CT, 8'h00);
      rchk(ZL, 8'h03);
      rchk(OL, 8'h02);
      wr(CT, 8'h01);
      pin_source_i.pulse(1);
      #1;
      `CHK(irq_req.ext_a, 1'b1)
      rchk(CT, 8'h03);
      ack(1);
      `CHK(irq_req.ext_a, 1'b0)
      pin_source_i.drive(0, 1'b0);
      repeat (40) @(posedge clk);
      #1;
      `CHK(irq_req.ext_b, 1'b1)
      ack(0);
      `CHK(irq_req.ext_b, 1'b1)
      pin_source_i.drive(0, 1'b1);
      repeat (40) @(posedge clk);
      wr(CT, 8'h00);
      rchk(CT, 8'h00);
      wr(tmr_pkg::TIMER_MODE_SELECT_ADDR, 8'h01);
      wr(CT, 8'hFF);
      resetn <= 1'b0;
      @(posedge clk);
      #1;
      `CHK(irq_req, 4'h0)
      do_reset();
      rchk(CT, 8'h00);
      rchk(tmr_pkg::TIMER_MODE_SELECT_ADDR, 8'h00);
      print_verdict();
   end

endmodule

`default_nettype wire

// ==== sim/pin_source.sv ====
// far side model: count pins and external interrupt pins, idle high
// assumes the bench calls its tasks from the block's clock domain
`default_nettype none

module pin_source (
   // clock
   input wire logic clk,
   // pins towards the block
   output var tmr_pkg::pins_s pins
);
   timeunit 1ns;
   timeprecision 100ps;

   localparam int HOLD = 30;

   logic [3:0] lv = 4'hF;

   assign pins = lv;

   ////////////////////////////////////////////////////////////////////////////////

   // sets one pin level just after an edge
   task automatic drive(input int i, input logic v);
      @(posedge clk);
      lv[i] <= v;
   endtask

   task automatic pulse(input int i);
      drive(i, 1'b0);
      repeat (HOLD) @(posedge clk);
      drive(i, 1'b1);
      repeat (HOLD) @(posedge clk);
   endtask

endmodule

`default_nettype wire
